// File: core/ciu_defs.vh
// Constants for the CPU interrupt control unit
`ifndef CIU_DEFS_VH
`define CIU_DEFS_VH
`define CIU_CCP_LSB      0
`define CIU_CCP_MSB      7
`define CIU_GIE_BIT      8
`define CIU_PEND_LSB     16
`define CIU_PEND_MSB     23
`define CIU_ARB_LSB      24
`define CIU_ARB_MSB      26
`define CIU_ICR_RESET    32'h0000_0000
`define CIU_PRIO_NONE    8'h00
`define CIU_VEC_SHIFT    5
`define CIU_PROV_CPU     2'h0
`define CIU_IO_ENTRY     2'h2
`define CIU_PRS_ENTRY    2'h0
`define CIU_IS_ENTRY     1'h1
`define CIU_CDC_ENTRY    7'h40
`define CIU_CTX_UPPER    2'h1
`define CIU_CTX_LOWER    2'h2
`define CIU_CTX_NONE     2'h0
`endif

// File: core/ciu_max_search.v
// Registered maximum search over request node priorities
`timescale 1ns/100ps
`include "ciu_defs.vh"
module ciu_max_search #(
  parameter NODES = 8
) (
  input  wire               ref_clk,
  input  wire               resetn,
  input  wire               clk_en,
  input  wire               start,
  input  wire [NODES-1:0]   part,
  input  wire [NODES*8-1:0] prio_flat,
  output reg                done_reg,
  output reg  [7:0]         max_reg,
  output reg  [NODES-1:0]   win_reg
);

  wire [7:0]       run [0:NODES];
  wire [NODES-1:0] hit;
  assign run[0] = `CIU_PRIO_NONE;

  // Chain compare; priority zero never beats the zero seed
  genvar g;
  generate
    for (g = 0; g < NODES; g = g + 1) begin : g_cmp
      wire [7:0] p = prio_flat[g*8 +: 8];
      assign run[g+1] = (part[g] && p > run[g]) ? p : run[g]; // RULE_21
      assign hit[g]   = part[g] && (p == run[NODES]) && (p != `CIU_PRIO_NONE);
    end
  endgenerate

  // One-cycle fixed latency result capture
  always @(posedge ref_clk) begin
    if (!resetn) begin
      done_reg <= 1'b0;
      max_reg  <= 8'h00;
      win_reg  <= {NODES{1'b0}};
    end else if (clk_en) begin
      done_reg <= start; // RULE_22
      if (start) begin
        max_reg <= run[NODES];
        win_reg <= hit;
      end
    end
  end
endmodule

// File: core/ciu_core.v
// CPU interrupt control unit: arbitration, control register, entry sequence
`timescale 1ns/100ps
`include "ciu_defs.vh"
// How it works
// RULE_01 - A newly raised participating request starts an arbitration round automatically.
// RULE_02 - Round end loads highest priority into pending field and raises CPU request.
// RULE_03 - Accept only with global enable set and pending above current priority.
// RULE_04 - CPU acknowledge is forwarded to the winning node, which clears its flag.
// RULE_05 - After acknowledge, pending clears and a new round runs, else idle.
// RULE_06 - Pending field is read-only, zero when none, cleared at round start.
// RULE_07 - Arbitration runs regardless of global enable or CPU blocking.
// RULE_08 - Requests raised during a round wait until the round ends.
// RULE_09 - Entry deferred while entering, in traps, multi-cycle or control-changing instructions.
// RULE_10 - Entry saves upper context, clears enable, then copies pending to current.
// RULE_11 - Entry loads status word defaults: io 10, prs 00, stack 1, depth 1000000.
// RULE_12 - Handler address is vector base ORed with pending shifted left five.
// RULE_13 - Current priority changes on entry, exit, bank instruction and core-register move.
// RULE_14 - Enable bit changes on entry, exit, enable, disable, bank and move.
// RULE_15 - Bank instruction sets enable, loads priority, saves lower context together.
// RULE_16 - Interrupts refused until enable, disable, bank or move instruction completes.
// RULE_17 - Three implementation arbitration control bits held at bits 26 and 25:24.
// RULE_18 - Control register resets to zero.
// RULE_19 - Arbitration proceeds concurrently, never stalling the CPU.
// RULE_20 - Only flagged, enabled nodes selecting the CPU take part.
// RULE_21 - Priority zero never wins nor is serviced.
// RULE_22 - Arbitration is a fixed-latency maximum search.
module ciu_core #(
  parameter NODES = 8
) (
  input  wire               ref_clk,
  input  wire               resetn,
  input  wire               clk_en,
  input  wire [NODES-1:0]   request_flag,
  input  wire [NODES-1:0]   request_enable,
  input  wire [NODES*2-1:0] provider_select,
  input  wire [NODES*8-1:0] request_priority,
  output reg  [NODES-1:0]   node_ack_reg,
  input  wire               cpu_entering,
  input  wire               cpu_trap_busy,
  input  wire               cpu_multi_cycle,
  input  wire               cpu_ctrl_instr,
  input  wire               cpu_rfe,
  input  wire               cpu_rfe_gie,
  input  wire [7:0]         cpu_rfe_ccp,
  input  wire               cpu_enable_instr,
  input  wire               cpu_disable_instr,
  input  wire               cpu_bank_instr,
  input  wire [7:0]         cpu_bank_prio,
  input  wire               cpu_move_to_core_reg_instr_icr,
  input  wire [31:0]        cpu_move_to_core_reg_instr_data,
  input  wire [31:0]        vector_base,
  output reg  [31:0]        interrupt_control_reg,
  output reg                irq_req_reg,
  output reg                irq_take_reg,
  output reg  [31:0]        handler_addr_reg,
  output reg  [1:0]         ctx_save_reg,
  output reg  [1:0]         io_permission_reg,
  output reg  [1:0]         protection_set_reg,
  output reg                irq_stack_select_reg,
  output reg  [6:0]         call_depth_field_reg,
  output reg                arb_busy_reg
);

  localparam S_IDLE  = 3'b001;
  localparam S_ARB   = 3'b010;
  localparam S_ENTRY = 3'b100;

  reg  [2:0]       state_reg;
  reg  [NODES-1:0] seen_reg;
  reg  [NODES-1:0] part_snap_reg;
  reg              rearb_reg;
  reg  [7:0]       pend_reg;
  reg  [NODES-1:0] winner_reg;
  reg  [1:0]       entry_step_reg;
  reg  [7:0]       ccp_reg;
  reg              gie_reg;
  reg  [2:0]       arb_ctl_reg;
  reg  [7:0]       taken_prio_reg;
  wire [NODES-1:0] part;
  wire             srch_done;
  wire [7:0]       srch_max;
  wire [NODES-1:0] srch_win;
  wire             new_req;
  wire             cpu_block;
  wire             accept;

  // Participation filter per node
  genvar g;
  generate
    for (g = 0; g < NODES; g = g + 1) begin : g_part
      assign part[g] = request_flag[g] && request_enable[g] &&
                       (provider_select[g*2 +: 2] == `CIU_PROV_CPU); // RULE_20
    end
  endgenerate

  // Rising participation since the last snapshot counts as new
  assign new_req = |(part & ~seen_reg); // RULE_01

  // Any CPU condition that defers acceptance
  assign cpu_block = cpu_entering | cpu_trap_busy | cpu_multi_cycle | cpu_ctrl_instr |
                     cpu_enable_instr | cpu_disable_instr | cpu_bank_instr |
                     cpu_move_to_core_reg_instr_icr | cpu_rfe; // RULE_09 RULE_16

  // Acceptance test kept strict, zero pending can never pass
  assign accept = irq_req_reg && gie_reg && (pend_reg > ccp_reg) && !cpu_block &&
                  (state_reg == S_IDLE); // RULE_03 RULE_21

  ciu_max_search #(
    .NODES (NODES)
  ) u_srch (
    .ref_clk   (ref_clk),
    .resetn    (resetn),
    .clk_en    (clk_en),
    .start     (state_reg == S_IDLE && (new_req || rearb_reg)),
    .part      (part),
    .prio_flat (request_priority),
    .done_reg  (srch_done),
    .max_reg   (srch_max),
    .win_reg   (srch_win)
  );

  // Arbitration and entry sequencing; runs beside the CPU, never stalls it
  always @(posedge ref_clk) begin
    if (!resetn) begin
      state_reg            <= S_IDLE;
      seen_reg             <= {NODES{1'b0}};
      part_snap_reg        <= {NODES{1'b0}};
      rearb_reg            <= 1'b0;
      pend_reg             <= `CIU_PRIO_NONE;
      winner_reg           <= {NODES{1'b0}};
      irq_req_reg          <= 1'b0;
      irq_take_reg         <= 1'b0;
      node_ack_reg         <= {NODES{1'b0}};
      entry_step_reg       <= 2'h0;
      ctx_save_reg         <= `CIU_CTX_NONE;
      handler_addr_reg     <= 32'h0000_0000;
      io_permission_reg    <= 2'h0;
      protection_set_reg   <= 2'h0;
      irq_stack_select_reg <= 1'b0;
      call_depth_field_reg <= 7'h00;
      ccp_reg              <= 8'h00; // RULE_18
      gie_reg              <= 1'b0;
      arb_ctl_reg          <= 3'h0;
      arb_busy_reg         <= 1'b0;
    end else if (clk_en) begin
      node_ack_reg <= {NODES{1'b0}};
      irq_take_reg <= 1'b0;
      ctx_save_reg <= `CIU_CTX_NONE;
      // Dropped requests leave the seen set so a re-raise is detected
      seen_reg <= seen_reg & part;
      case (state_reg)
        S_IDLE: begin
          if (accept) begin
            node_ack_reg   <= winner_reg; // RULE_04
            irq_req_reg    <= 1'b0;
            irq_take_reg   <= 1'b1;
            pend_reg       <= `CIU_PRIO_NONE; // RULE_05
            rearb_reg      <= 1'b1;
            entry_step_reg <= 2'h0;
            state_reg      <= S_ENTRY;
          end else if (new_req || rearb_reg) begin
            // Snapshot fixes the round; later requests wait for the next
            part_snap_reg <= part; // RULE_08
            seen_reg      <= part;
            rearb_reg     <= 1'b0;
            pend_reg      <= `CIU_PRIO_NONE; // RULE_06
            irq_req_reg   <= 1'b0;
            arb_busy_reg  <= 1'b1; // RULE_07 RULE_19
            state_reg     <= S_ARB;
          end
        end
        S_ARB: begin
          if (srch_done) begin
            pend_reg     <= srch_max; // RULE_02
            winner_reg   <= srch_win & part_snap_reg;
            irq_req_reg  <= (srch_max != `CIU_PRIO_NONE);
            arb_busy_reg <= 1'b0;
            state_reg    <= S_IDLE;
          end
        end
        S_ENTRY: begin
          // Ordered steps: save upper context, clear enable, take priority
          case (entry_step_reg)
            2'h0: begin
              ctx_save_reg   <= `CIU_CTX_UPPER; // RULE_10
              entry_step_reg <= 2'h1;
            end
            2'h1: begin
              gie_reg        <= 1'b0; // RULE_10 RULE_14
              entry_step_reg <= 2'h2;
            end
            default: begin
              ccp_reg              <= taken_prio_reg; // RULE_10 RULE_13
              io_permission_reg    <= `CIU_IO_ENTRY; // RULE_11
              protection_set_reg   <= `CIU_PRS_ENTRY;
              irq_stack_select_reg <= `CIU_IS_ENTRY;
              call_depth_field_reg <= `CIU_CDC_ENTRY;
              handler_addr_reg     <= vector_base |
                                      ({24'h000000, taken_prio_reg} << `CIU_VEC_SHIFT); // RULE_12
              state_reg            <= S_IDLE;
            end
          endcase
        end
        default: state_reg <= S_IDLE;
      endcase
      // CPU instruction side updates of enable and current priority
      if (state_reg != S_ENTRY) begin
        if (cpu_move_to_core_reg_instr_icr) begin
          ccp_reg     <= cpu_move_to_core_reg_instr_data[`CIU_CCP_MSB:`CIU_CCP_LSB]; // RULE_13
          gie_reg     <= cpu_move_to_core_reg_instr_data[`CIU_GIE_BIT]; // RULE_14
          arb_ctl_reg <= cpu_move_to_core_reg_instr_data[`CIU_ARB_MSB:`CIU_ARB_LSB]; // RULE_17
        end else if (cpu_bank_instr) begin
          gie_reg      <= 1'b1; // RULE_15
          ccp_reg      <= cpu_bank_prio;
          ctx_save_reg <= `CIU_CTX_LOWER;
        end else if (cpu_rfe) begin
          gie_reg <= cpu_rfe_gie;
          ccp_reg <= cpu_rfe_ccp;
        end else if (cpu_enable_instr) begin
          gie_reg <= 1'b1; // RULE_14
        end else if (cpu_disable_instr) begin
          gie_reg <= 1'b0;
        end
      end
    end
  end

  // Priority taken at acceptance, held for the entry steps
  always @(posedge ref_clk) begin
    if (!resetn) begin
      taken_prio_reg <= 8'h00;
    end else if (clk_en && accept) begin
      taken_prio_reg <= pend_reg;
    end
  end

  // Visible control register; pending field has no software write path
  always @(posedge ref_clk) begin
    if (!resetn) begin
      interrupt_control_reg <= `CIU_ICR_RESET; // RULE_18
    end else if (clk_en) begin
      interrupt_control_reg <= {5'h00, arb_ctl_reg, pend_reg, 7'h00, gie_reg, ccp_reg}; // RULE_06
    end
  end
endmodule

// File: dv/ciu_node_model.sv
// Behavioural request nodes holding their request flags
`timescale 1ns/100ps
module ciu_node_model #(
  parameter NODES = 8
) (
  input  logic             ref_clk,
  input  logic             resetn,
  input  logic [NODES-1:0] raise,
  input  logic [NODES-1:0] node_ack,
  output logic [NODES-1:0] request_flag
);
  // Raise sets a flag; only the node's own acknowledge clears it
  always @(posedge ref_clk) begin
    if (!resetn) begin
      request_flag <= '0;
    end else begin
      request_flag <= (request_flag & ~node_ack) | raise;
    end
  end
endmodule

// File: dv/ciu_checker.sv
// Concurrent checks on the interrupt control unit ports
`timescale 1ns/100ps
module ciu_checker #(
  parameter NODES = 8
) (
  input logic             ref_clk,
  input logic             resetn,
  input logic             cpu_multi_cycle,
  input logic [31:0]      vector_base,
  input logic [31:0]      interrupt_control_reg,
  input logic             irq_req_reg,
  input logic             irq_take_reg,
  input logic [31:0]      handler_addr_reg,
  input logic [1:0]       ctx_save_reg,
  input logic [1:0]       io_permission_reg,
  input logic [1:0]       protection_set_reg,
  input logic             irq_stack_select_reg,
  input logic [6:0]       call_depth_field_reg,
  input logic             arb_busy_reg,
  input logic [NODES-1:0] node_ack_reg
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!resetn);
  // Status word defaults seen together, one cycle after the gie clear
  sequence s_entry_dflt;
    io_permission_reg == 2'h2 && protection_set_reg == 2'h0 &&
    irq_stack_select_reg && call_depth_field_reg == 7'h40;
  endsequence
  a_reset_zero: assert property (
    $rose(resetn) |-> interrupt_control_reg == 32'h0) else $error("register not cleared");
  a_ack_onehot: assert property (
    node_ack_reg != 0 |-> $onehot(node_ack_reg)) else $error("ack to several nodes");
  a_take_ack: assert property (
    irq_take_reg |-> node_ack_reg != 0 ##1 ctx_save_reg == 2'h1) else $error("take no ack");
  a_take_cause: assert property (
    irq_take_reg |-> $past(irq_req_reg) && !$past(cpu_multi_cycle)) else $error("bad take");
  a_gie_clear: assert property (
    irq_take_reg |-> ##[1:3] !interrupt_control_reg[8]) else $error("gie kept on entry");
  a_entry_dflt: assert property (
    irq_take_reg |-> ##3 s_entry_dflt) else $error("status defaults wrong");
  a_vector_or: assert property (
    irq_take_reg |-> ##3 handler_addr_reg ==
      (vector_base | {19'h0, $past(interrupt_control_reg[23:16], 3), 5'h0}) ##1
      interrupt_control_reg[7:0] == $past(interrupt_control_reg[23:16], 4))
    else $error("bad vector");
  a_pend_valid: assert property (
    $rose(irq_req_reg) |=> interrupt_control_reg[23:16] != 8'h00) else $error("empty req");
  a_round_clear: assert property (
    $rose(arb_busy_reg) |-> ##[0:2] interrupt_control_reg[23:16] == 8'h00)
    else $error("pending not cleared");
  a_round_len: assert property (
    $rose(arb_busy_reg) |-> ##[1:3] !arb_busy_reg) else $error("round too long");
endmodule
bind ciu_core ciu_checker #(.NODES(NODES)) chk_i (
  .ref_clk(ref_clk), .resetn(resetn), .cpu_multi_cycle(cpu_multi_cycle),
  .vector_base(vector_base), .interrupt_control_reg(interrupt_control_reg),
  .irq_req_reg(irq_req_reg), .irq_take_reg(irq_take_reg), .arb_busy_reg(arb_busy_reg),
  .handler_addr_reg(handler_addr_reg), .ctx_save_reg(ctx_save_reg),
  .io_permission_reg(io_permission_reg), .protection_set_reg(protection_set_reg),
  .irq_stack_select_reg(irq_stack_select_reg), .node_ack_reg(node_ack_reg),
  .call_depth_field_reg(call_depth_field_reg));

// File: dv/test_cpu_interrupt_control_unit.sv
// Self-checking bench for the CPU interrupt control unit
`timescale 1ns/100ps
module test_cpu_interrupt_control_unit;
  logic        ref_clk, resetn, clk_en, cpu_multi_cycle, irq_req, take, busy, is_stk;
  logic [4:0]  pls;
  logic [2:0]  blk;
  logic        rfe_gie;
  logic [7:0]  rfe_ccp;
  logic [7:0]  bank_prio, enable, raise, flag, ack;
  logic [15:0] prov;
  logic [63:0] prio;
  logic [31:0] move_to_core_reg_instr_data, vbase, interrupt_control, handler;
  logic [1:0]  ctx, io, prs;
  logic [6:0]  cdc;
  int          err_count, cmp_count, cyc;
  ciu_core #(.NODES(8)) uut (
    .ref_clk(ref_clk), .resetn(resetn), .clk_en(clk_en), .request_flag(flag),
    .request_enable(enable), .provider_select(prov), .request_priority(prio),
    .node_ack_reg(ack), .cpu_entering(blk[0]), .cpu_trap_busy(blk[1]),
    .cpu_multi_cycle(cpu_multi_cycle), .cpu_ctrl_instr(blk[2]), .cpu_rfe(pls[0]),
    .cpu_rfe_gie(rfe_gie), .cpu_rfe_ccp(rfe_ccp), .cpu_enable_instr(pls[1]),
    .cpu_disable_instr(pls[2]), .cpu_bank_instr(pls[3]), .cpu_bank_prio(bank_prio),
    .cpu_move_to_core_reg_instr_icr(pls[4]), .cpu_move_to_core_reg_instr_data(move_to_core_reg_instr_data), .vector_base(vbase),
    .interrupt_control_reg(interrupt_control), .irq_req_reg(irq_req), .irq_take_reg(take),
    .handler_addr_reg(handler), .ctx_save_reg(ctx), .io_permission_reg(io),
    .protection_set_reg(prs), .irq_stack_select_reg(is_stk),
    .call_depth_field_reg(cdc), .arb_busy_reg(busy));
  ciu_node_model #(.NODES(8)) nodes (
    .ref_clk(ref_clk), .resetn(resetn), .raise(raise), .node_ack(ack),
    .request_flag(flag));
  always #25 ref_clk = ~ref_clk;
  // Hang guard: whole run needs well under a hundred cycles
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 2000) begin
      err_count++;
      close_out;
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // One-cycle CPU instruction pulse, bit index picks the instruction
  task automatic pulse(input int b);
    @(negedge ref_clk) pls[b] = 1'b1;
    @(negedge ref_clk) pls = 5'h0;
  endtask
  task automatic wait_req;
    for (int i = 0; i < 30 && irq_req !== 1'b1; i++) @(negedge ref_clk);
    chk(irq_req, 1);
    @(negedge ref_clk); // Register image lags one cycle
  endtask
  task automatic wait_take;
    for (int i = 0; i < 30 && take !== 1'b1; i++) @(negedge ref_clk);
    chk(take, 1);
  endtask
  task automatic t_reset;
    chk(interrupt_control, 32'h0);
    chk(irq_req, 0);
    $display("t_reset done");
  endtask
  // Mixed nodes with interrupts off: disabled, other provider, zero priority
  task automatic t_poll;
    pulse(2);
    prio = {8'h30, 8'h20, 8'h09, 8'h00, 8'h00, 8'h05, 8'h00, 8'h00};
    enable = 8'hbf;
    prov = 16'h4000;
    @(negedge ref_clk) raise = 8'hec;
    @(negedge ref_clk) raise = 8'h00;
    wait_req;
    chk(interrupt_control[23:16], 8'h09);
    chk(flag, 8'hec);
    $display("t_poll done");
  endtask
  // Equal priority refused, then bank instruction lowers priority and entry runs
  task automatic t_take;
    move_to_core_reg_instr_data = 32'h05ff_0009;
    pulse(4);
    pulse(1);
    repeat (4) @(negedge ref_clk);
    chk(interrupt_control[15:0], 16'h0109);
    chk(interrupt_control[26:16], 11'h509);
    chk(flag[5], 1);
    pulse(2);
    repeat (2) @(negedge ref_clk);
    chk(interrupt_control[8], 0);
    bank_prio = 8'h04;
    pulse(3);
    wait_take;
    chk(ack, 8'h20);
    repeat (4) @(negedge ref_clk);
    chk(interrupt_control[15:0], 16'h0009);
    chk(handler, 32'h0000_4120);
    chk({io, prs, is_stk, cdc}, {2'h2, 2'h0, 1'h1, 7'h40});
    chk(flag[5], 0);
    wait_req;
    chk(interrupt_control[23:16], 8'h05);
    $display("t_take done");
  endtask
  // Multi-cycle, entry, trap and control instructions each defer the take
  task automatic t_defer;
    vbase = 32'h0000_8000;
    cpu_multi_cycle = 1;
    rfe_gie = 1;
    rfe_ccp = 8'h03;
    pulse(0);
    clk_en = 0;
    repeat (2) @(negedge ref_clk);
    clk_en = 1;
    repeat (6) @(negedge ref_clk);
    chk(flag[2], 1);
    chk(interrupt_control[8:0], 9'h103);
    cpu_multi_cycle = 0;
    for (int i = 0; i < 3; i++) begin
      blk = 3'h1 << i;
      repeat (3) @(negedge ref_clk);
      chk(flag[2], 1);
    end
    blk = 3'h0;
    wait_take;
    chk(ack, 8'h04);
    repeat (8) @(negedge ref_clk);
    chk(handler, 32'h0000_80a0);
    chk(interrupt_control[23:16], 8'h00);
    chk(irq_req, 0);
    $display("t_defer done");
  endtask
  task automatic close_out;
    $display("comparisons %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  initial begin
    {ref_clk, resetn, cpu_multi_cycle, pls, raise, enable, prov, prio} = '0;
    {bank_prio, move_to_core_reg_instr_data, err_count, cmp_count, cyc} = '0;
    {blk, rfe_gie, rfe_ccp} = '0;
    clk_en = 1;
    vbase = 32'h0000_4000;
    repeat (4) @(negedge ref_clk);
    resetn = 1;
    t_reset;
    t_poll;
    t_take;
    t_defer;
    close_out;
  end
endmodule
